// file: logic/fac_ctrl.sv
// nonvolatile array access controller: cpu port, cache, wait states, ecc events, registers
`timescale 1ns/1ps
module fac_ctrl import fac_pkg::*; (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 srst_i,
	// cpu memory port
	input  wire fac_cpu_req_t         cpu_req_i,
	output logic                      cpu_ready_o,
	output logic                      cpu_ack_o,
	output logic [DATA_W-1:0]         cpu_rdata_o,
	// array port
	output fac_arr_req_t              arr_req_o,
	input  wire logic [LINE_W-1:0]    arr_rdata_i,
	input  wire logic                 arr_err_single_i,
	input  wire logic                 arr_err_multi_i,
	// clock system: least wait count the present clock needs
	input  wire logic [WAIT_W-1:0]    clk_wait_need_i,
	// register port
	input  wire logic [REG_A_W-1:0]   reg_addr_i,
	input  wire logic [15:0]          reg_wdata_i,
	input  wire logic [1:0]           reg_be_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic [15:0]               reg_rdata_o,
	// system events
	output logic                      system_nmi_event_o,
	output logic [NMI_SRC_W-1:0]      system_nmi_vector_generator_o,
	output logic                      system_reset_event_o,
	output logic                      power_up_clear_o,
	output logic [RST_SRC_W-1:0]      system_reset_vector_generator_o
);

	typedef enum logic [1:0] {S_IDLE, S_RD_WAIT, S_WB_WAIT, S_WR_WAIT} fac_state_t;

	fac_state_t          state_ff, nxt_state;
	logic [WAIT_W-1:0]   cnt_ff, nxt_cnt;
	logic [ADDR_W-1:0]   addr_ff, nxt_addr;
	logic [LINE_W-1:0]   line_ff, nxt_line;
	fac_arr_req_t        arr_ff, nxt_arr;
	logic                ack_ff, nxt_ack;
	logic [DATA_W-1:0]   rdata_ff, nxt_rdata;
	logic                ready_ff;

	logic [WAIT_W-1:0]   wait_count_ff;
	logic                unlocked_ff;
	logic [15:0]         gctrl_ff;
	logic                correctable_error_flag_ff;
	logic                uncorrectable_error_flag_ff;
	logic [15:0]         reg_rdata_ff;
	logic                nmi_ff;
	logic [NMI_SRC_W-1:0] nmi_src_ff;
	logic                sys_rst_ff;
	logic                puc_ff;
	logic [RST_SRC_W-1:0] rst_src_ff;

	//////////////////////////////////////////////////////////////////////////////
	// cpu request decode
	wire take_rd = ready_ff && cpu_req_i.rd;
	wire take_wr = ready_ff && cpu_req_i.wr && !cpu_req_i.rd;
	wire [ADDR_W-1:0] look_addr = (state_ff == S_IDLE) ? cpu_req_i.addr : addr_ff;

	wire in_desc = (cpu_req_i.addr >= DESC_LO) && (cpu_req_i.addr <= DESC_HI);
	wire in_info = (cpu_req_i.addr >= INFO_LO) && (cpu_req_i.addr <= INFO_HI);
	// descriptor region is read-only, info region flagged to the array
	wire [1:0] region = in_desc ? REGION_DESC : (in_info ? REGION_INFO : REGION_MAIN);

	// byte lanes of the word placed into the 64-bit line
	wire [MASK_W-1:0] wr_mask =
		MASK_W'({6'h00, cpu_req_i.be} << {cpu_req_i.addr[1:0], 1'b0});
	wire [LINE_W-1:0] wr_line = {4{cpu_req_i.wdata}};

	wire              cache_hit;
	wire [DATA_W-1:0] cache_word;
	wire              cnt_done = (cnt_ff == '0);
	wire              capture  = (state_ff == S_RD_WAIT) && cnt_done;

	//////////////////////////////////////////////////////////////////////////////
	// ecc events at the end of each array read
	wire ecc_cor   = capture && arr_err_single_i;
	wire ecc_unc   = capture && arr_err_multi_i;
	wire cor_ie    = gctrl_ff[GC_COR_IE_BIT];
	wire unc_ie    = gctrl_ff[GC_UNC_IE_BIT];
	wire unc_rst   = ecc_unc && gctrl_ff[GC_RST_EN_BIT];
	wire nmi_cor   = ecc_cor && cor_ie;
	wire nmi_unc   = ecc_unc && unc_ie && !unc_rst;

	//////////////////////////////////////////////////////////////////////////////
	// register write decode
	wire       wr_ctrl   = reg_wr_i && (reg_addr_i == REG_CTRL0);
	wire       wr_other  = reg_wr_i && (reg_addr_i != REG_CTRL0);
	wire       key_write = wr_ctrl && reg_be_i[1];
	wire       key_ok    = reg_wdata_i[15:8] == KEY_UNLOCK;
	wire       key_word  = reg_be_i == 2'b11;
	wire       key_bad_w = key_write && !key_ok && key_word;
	wire       locked_wr = wr_other && !unlocked_ff;
	// a word carrying a wrong key must not land its wait field
	wire       wr_wait   = wr_ctrl && reg_be_i[0] && (key_write ? key_ok : unlocked_ff);
	wire       wr_gctrl  = reg_wr_i && unlocked_ff && (reg_addr_i == REG_GCTRL0);
	wire       wr_stat   = reg_wr_i && unlocked_ff && (reg_addr_i == REG_ERRSTAT);
	wire       clr_cor   = wr_stat && reg_be_i[0] && reg_wdata_i[ST_COR_BIT];
	wire       clr_unc   = wr_stat && reg_be_i[0] && reg_wdata_i[ST_UNC_BIT];
	wire [15:0] be_mask  = {{8{reg_be_i[1]}}, {8{reg_be_i[0]}}} & GC_WMASK;
	wire       timing_bad = wait_count_ff < clk_wait_need_i;

	wire [RST_SRC_W-1:0] nxt_rst_src =
		unc_rst    ? RST_SRC_UNC    :
		key_bad_w  ? RST_SRC_KEY    :
		locked_wr  ? RST_SRC_LOCKED :
		timing_bad ? RST_SRC_TIMING : RST_SRC_NONE;

	wire [15:0] rd_mux =
		(reg_addr_i == REG_CTRL0)   ? {KEY_READ, 1'b0, wait_count_ff, 4'h0} :
		(reg_addr_i == REG_GCTRL0)  ? gctrl_ff :
		(reg_addr_i == REG_ERRSTAT) ? {14'h0000, uncorrectable_error_flag_ff,
		                               correctable_error_flag_ff} : 16'h0000;

	//////////////////////////////////////////////////////////////////////////////
	fac_read_cache u_cache (
		.sys_clk_i   (sys_clk_i),
		.srst_i      (srst_i),
		.look_addr_i (look_addr),
		.look_hit_o  (cache_hit),
		.look_word_o (cache_word),
		.touch_i     (take_rd),
		.fill_i      (capture),
		.fill_data_i (arr_rdata_i),
		.upd_i       (take_wr && !in_desc),
		.upd_data_i  (wr_line),
		.upd_mask_i  (wr_mask)
	);

	//////////////////////////////////////////////////////////////////////////////
	// access sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_addr  = addr_ff;
		nxt_line  = line_ff;
		nxt_arr   = '0;
		nxt_ack   = 1'b0;
		nxt_rdata = rdata_ff;
		case (state_ff)
			S_IDLE: begin
				if (take_rd && cache_hit) begin
					// plain sram-like read served at full speed
					nxt_ack   = 1'b1;
					nxt_rdata = cache_word;
				end else if (take_rd) begin
					// miss: fetch the aligned four-word line
					nxt_addr       = cpu_req_i.addr;
					nxt_arr.rd     = 1'b1;
					nxt_arr.line   = cpu_req_i.addr[ADDR_W-1:2];
					nxt_arr.region = region;
					nxt_cnt        = wait_count_ff;
					nxt_state      = S_RD_WAIT;
				end else if (take_wr && in_desc) begin
					nxt_ack = 1'b1;
				end else if (take_wr) begin
					nxt_addr       = cpu_req_i.addr;
					nxt_arr.wr     = 1'b1;
					nxt_arr.line   = cpu_req_i.addr[ADDR_W-1:2];
					nxt_arr.wdata  = wr_line;
					nxt_arr.wmask  = wr_mask;
					nxt_arr.region = region;
					nxt_cnt        = wait_count_ff;
					nxt_state      = S_WR_WAIT;
				end
			end
			S_RD_WAIT: begin
				if (cnt_done) begin
					// return word and restore the same line
					nxt_ack        = 1'b1;
					nxt_rdata      = line_word(arr_rdata_i, addr_ff[1:0]);
					nxt_line       = arr_rdata_i;
					nxt_arr.wb     = 1'b1;
					nxt_arr.line   = addr_ff[ADDR_W-1:2];
					nxt_arr.wdata  = arr_rdata_i;
					nxt_arr.wmask  = '1;
					nxt_arr.region = arr_ff.region;
					nxt_cnt        = wait_count_ff;
					nxt_state      = S_WB_WAIT;
				end else begin
					// stall for the programmed wait states
					nxt_cnt = cnt_ff - 3'h1;
					nxt_arr = arr_ff;
					nxt_arr.rd = 1'b0;
				end
			end
			S_WB_WAIT, S_WR_WAIT: begin
				if (cnt_done) begin
					nxt_ack   = (state_ff == S_WR_WAIT);
					nxt_state = S_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 3'h1;
					nxt_arr = arr_ff;
					nxt_arr.wr = 1'b0;
					nxt_arr.wb = 1'b0;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_ff <= S_IDLE;
			cnt_ff   <= '0;
			addr_ff  <= '0;
			line_ff  <= '0;
			arr_ff   <= '0;
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
			ready_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			addr_ff  <= nxt_addr;
			line_ff  <= nxt_line;
			arr_ff   <= nxt_arr;
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
			ready_ff <= (nxt_state == S_IDLE);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wait_count_ff <= WAIT_RESET;
			unlocked_ff   <= 1'b0;
			gctrl_ff      <= GC_RESET;
			reg_rdata_ff  <= '0;
		end else begin
			if (key_write) begin
				// correct key opens, wrong byte key closes without clear
				unlocked_ff <= key_ok;
			end
			if (wr_wait) begin
				wait_count_ff <= reg_wdata_i[WAIT_MSB:WAIT_LSB];
			end
			if (wr_gctrl) begin
				gctrl_ff <= (gctrl_ff & ~be_mask) | (reg_wdata_i & be_mask);
			end
			if (reg_rd_i) begin
				reg_rdata_ff <= rd_mux;
			end
		end
	end

	// sticky error flags, a new error wins over a clear
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			correctable_error_flag_ff   <= 1'b0;
			uncorrectable_error_flag_ff <= 1'b0;
		end else begin
			correctable_error_flag_ff   <= ecc_cor ||
				(correctable_error_flag_ff && !clr_cor);
			uncorrectable_error_flag_ff <= ecc_unc ||
				(uncorrectable_error_flag_ff && !clr_unc);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// system event outputs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			nmi_ff     <= 1'b0;
			nmi_src_ff <= NMI_SRC_NONE;
			sys_rst_ff <= 1'b0;
			puc_ff     <= 1'b0;
			rst_src_ff <= RST_SRC_NONE;
		end else begin
			nmi_ff     <= nmi_cor || nmi_unc;
			// uncorrectable outranks correctable in the vector
			nmi_src_ff <= nmi_unc ? NMI_SRC_UNC : (nmi_cor ? NMI_SRC_COR : NMI_SRC_NONE);
			sys_rst_ff <= unc_rst;
			// clear on reset error, bad word key, locked write or timing
			puc_ff     <= nxt_rst_src != RST_SRC_NONE;
			if (nxt_rst_src != RST_SRC_NONE) begin
				rst_src_ff <= nxt_rst_src;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	assign cpu_ready_o                     = ready_ff;
	assign cpu_ack_o                       = ack_ff;
	assign cpu_rdata_o                     = rdata_ff;
	assign arr_req_o                       = arr_ff;
	assign reg_rdata_o                     = reg_rdata_ff;
	assign system_nmi_event_o              = nmi_ff;
	assign system_nmi_vector_generator_o   = nmi_src_ff;
	assign system_reset_event_o            = sys_rst_ff;
	assign power_up_clear_o                = puc_ff;
	assign system_reset_vector_generator_o = rst_src_ff;

endmodule

// file: logic/fac_pkg.sv
// shared constants, types and helpers of the nonvolatile array access controller
package fac_pkg;

	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 16;
	localparam int LINE_W    = 64;
	localparam int MASK_W    = LINE_W / 8;
	localparam int WAIT_W    = 3;
	localparam int LINE_A_W  = ADDR_W - 2;
	localparam int SET_BIT   = 2;
	localparam int TAG_W     = ADDR_W - SET_BIT - 1;
	localparam int REG_A_W   = 4;
	localparam int RST_SRC_W = 3;
	localparam int NMI_SRC_W = 2;

	// register byte addresses
	localparam logic [REG_A_W-1:0] REG_CTRL0   = 4'h0;
	localparam logic [REG_A_W-1:0] REG_GCTRL0  = 4'h4;
	localparam logic [REG_A_W-1:0] REG_ERRSTAT = 4'h8;

	// control register 0 layout
	localparam logic [7:0]  KEY_UNLOCK  = 8'hA5;
	localparam logic [7:0]  KEY_READ    = 8'h96;
	localparam int          WAIT_LSB    = 4;
	localparam int          WAIT_MSB    = 6;
	localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h0;

	// general control 0 layout
	localparam int          GC_RST_EN_BIT = 7;
	localparam int          GC_UNC_IE_BIT = 6;
	localparam int          GC_COR_IE_BIT = 5;
	localparam logic [15:0] GC_RESET      = 16'h0006;
	localparam logic [15:0] GC_WMASK      = 16'h00EE;

	// error status layout, write one to clear
	localparam int ST_COR_BIT = 0;
	localparam int ST_UNC_BIT = 1;

	// word address regions
	localparam logic [ADDR_W-1:0] DESC_LO = 16'h0000;
	localparam logic [ADDR_W-1:0] DESC_HI = 16'h00FF;
	localparam logic [ADDR_W-1:0] INFO_LO = 16'h0100;
	localparam logic [ADDR_W-1:0] INFO_HI = 16'h01FF;
	localparam logic [1:0] REGION_MAIN = 2'h0;
	localparam logic [1:0] REGION_INFO = 2'h1;
	localparam logic [1:0] REGION_DESC = 2'h2;

	// nmi source and reset cause codes
	localparam logic [NMI_SRC_W-1:0] NMI_SRC_NONE = 2'h0;
	localparam logic [NMI_SRC_W-1:0] NMI_SRC_COR  = 2'h1;
	localparam logic [NMI_SRC_W-1:0] NMI_SRC_UNC  = 2'h2;
	localparam logic [RST_SRC_W-1:0] RST_SRC_NONE   = 3'h0;
	localparam logic [RST_SRC_W-1:0] RST_SRC_UNC    = 3'h1;
	localparam logic [RST_SRC_W-1:0] RST_SRC_KEY    = 3'h2;
	localparam logic [RST_SRC_W-1:0] RST_SRC_LOCKED = 3'h3;
	localparam logic [RST_SRC_W-1:0] RST_SRC_TIMING = 3'h4;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        be;
	} fac_cpu_req_t;

	typedef struct packed {
		logic                rd;
		logic                wr;
		logic                wb;
		logic [LINE_A_W-1:0] line;
		logic [LINE_W-1:0]   wdata;
		logic [MASK_W-1:0]   wmask;
		logic [1:0]          region;
	} fac_arr_req_t;

	function automatic logic [DATA_W-1:0] line_word(input logic [LINE_W-1:0] line,
		input logic [1:0] sel);
		line_word = line[sel*DATA_W +: DATA_W];
	endfunction

	function automatic logic [LINE_W-1:0] merge_line(input logic [LINE_W-1:0] old_line,
		input logic [LINE_W-1:0] new_line, input logic [MASK_W-1:0] mask);
		merge_line = old_line;
		for (int b = 0; b < MASK_W; b++) begin
			if (mask[b]) begin
				merge_line[b*8 +: 8] = new_line[b*8 +: 8];
			end
		end
	endfunction

endpackage

// file: logic/fac_read_cache.sv
// two-set, two-way read cache with per-set replacement pointer
`timescale 1ns/1ps
module fac_read_cache import fac_pkg::*; (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              srst_i,
	// lookup
	input  wire logic [ADDR_W-1:0] look_addr_i,
	output logic                   look_hit_o,
	output logic [DATA_W-1:0]      look_word_o,
	input  wire logic              touch_i,
	// fill and write update
	input  wire logic              fill_i,
	input  wire logic [LINE_W-1:0] fill_data_i,
	input  wire logic              upd_i,
	input  wire logic [LINE_W-1:0] upd_data_i,
	input  wire logic [MASK_W-1:0] upd_mask_i
);

	logic [TAG_W-1:0]  tag_ff   [2][2];
	logic              valid_ff [2][2];
	logic [LINE_W-1:0] data_ff  [2][2];
	logic              lru_ff   [2];

	wire              set_idx = look_addr_i[SET_BIT];
	wire [TAG_W-1:0]  tag_in  = look_addr_i[ADDR_W-1:SET_BIT+1];
	wire              hit0    = valid_ff[set_idx][0] && (tag_ff[set_idx][0] == tag_in);
	wire              hit1    = valid_ff[set_idx][1] && (tag_ff[set_idx][1] == tag_in);
	wire              hit_way = hit1;
	wire              victim  = lru_ff[set_idx];
	wire [LINE_W-1:0] hit_line = hit_way ? data_ff[set_idx][1] : data_ff[set_idx][0];

	assign look_hit_o  = hit0 || hit1;
	assign look_word_o = line_word(hit_line, look_addr_i[1:0]);

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			for (int s = 0; s < 2; s++) begin
				lru_ff[s]      <= 1'b0;
				valid_ff[s][0] <= 1'b0;
				valid_ff[s][1] <= 1'b0;
			end
		end else if (fill_i) begin
			// new line replaces the older way, recent data stays in the other
			data_ff[set_idx][victim]  <= fill_data_i;
			tag_ff[set_idx][victim]   <= tag_in;
			valid_ff[set_idx][victim] <= 1'b1;
			lru_ff[set_idx]           <= ~victim;
		end else if (look_hit_o && (touch_i || upd_i)) begin
			lru_ff[set_idx] <= ~hit_way;
			if (upd_i) begin
				data_ff[set_idx][hit_way] <= merge_line(hit_line, upd_data_i, upd_mask_i);
			end
		end
	end

endmodule

// file: testbench/fac_arr_mdl.sv
// behavioural model of the nonvolatile array behind the controller
`timescale 1ns/1ps
module fac_arr_mdl import fac_pkg::*; (
	// clock and array request
	input  wire logic              sys_clk_i,
	input  wire fac_arr_req_t      req_i,
	// wait count in force and error injection
	input  wire logic [WAIT_W-1:0] wait_i,
	input  wire logic [1:0]        inj_i,
	// read answer
	output logic [LINE_W-1:0]      rdata_o,
	output logic                   err_single_o,
	output logic                   err_multi_o
);
	logic [LINE_W-1:0] mem [0:63];
	logic [3:0]        cnt_ff = 4'h0;
	logic [LINE_W-1:0] junk_ff = '0;
	wire  [5:0]        idx = req_i.line[5:0];
	wire               valid = (wait_i == 3'h0) ? req_i.rd : (cnt_ff == {1'b0, wait_i});
	initial for (int i = 0; i < 256; i++) mem[i / 4][(i % 4) * 16 +: 16] = {8'(i), 8'h5A};
	// whole line only in the answer cycle, a changing pattern otherwise
	assign rdata_o      = valid ? mem[idx] : junk_ff;
	assign err_single_o = valid & inj_i[0];
	assign err_multi_o  = valid & inj_i[1];
	always @(posedge sys_clk_i) begin
		junk_ff <= ~rdata_o;
		cnt_ff  <= req_i.rd ? 4'h1 :
			(cnt_ff != 4'h0 && cnt_ff < {1'b0, wait_i}) ? cnt_ff + 4'h1 : 4'h0;
		for (int b = 0; b < 8; b++) begin
			if ((req_i.wr || req_i.wb) && req_i.wmask[b]) begin
				mem[idx][b * 8 +: 8] <= req_i.wdata[b * 8 +: 8];
			end
		end
	end
endmodule

// file: testbench/fac_ctrl_chk.sv
// port assertions of the array access controller
`timescale 1ns/1ps
module fac_ctrl_chk import fac_pkg::*; (
	// clock, reset and cpu port
	input wire logic                 sys_clk_i,
	input wire logic                 srst_i,
	input wire fac_cpu_req_t         cpu_req_i,
	input wire logic                 cpu_ready_o,
	input wire logic                 cpu_ack_o,
	input wire logic [DATA_W-1:0]    cpu_rdata_o,
	// array port and clock system
	input wire fac_arr_req_t         arr_req_o,
	input wire logic [LINE_W-1:0]    arr_rdata_i,
	input wire logic                 arr_err_single_i,
	input wire logic                 arr_err_multi_i,
	input wire logic [WAIT_W-1:0]    clk_wait_need_i,
	// registers and events
	input wire logic [REG_A_W-1:0]   reg_addr_i,
	input wire logic [15:0]          reg_wdata_i,
	input wire logic [1:0]           reg_be_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire logic [15:0]          reg_rdata_o,
	input wire logic                 system_nmi_event_o,
	input wire logic [NMI_SRC_W-1:0] system_nmi_vector_generator_o,
	input wire logic                 system_reset_event_o,
	input wire logic                 power_up_clear_o,
	input wire logic [RST_SRC_W-1:0] system_reset_vector_generator_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	logic [2:0]  w_ff;
	logic [3:0]  rc_ff;
	logic [63:0] cap_ff;
	logic [1:0]  sel_ff;
	logic [1:0]  be_ff;
	wire key_wr  = reg_wr_i && reg_addr_i == REG_CTRL0 && reg_be_i == 2'h3;
	wire key_ok  = key_wr && reg_wdata_i[15:8] == KEY_UNLOCK;
	wire bad_key = key_wr && reg_wdata_i[15:8] != KEY_UNLOCK;
	wire take    = cpu_ready_o && (cpu_req_i.rd || cpu_req_i.wr);
	wire cap_now = (w_ff == 3'h0) ? arr_req_o.rd : (rc_ff == {1'b0, w_ff});
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			w_ff  <= 3'h0;
			rc_ff <= 4'h0;
		end else begin
			if (key_ok) w_ff <= reg_wdata_i[WAIT_MSB:WAIT_LSB];
			rc_ff <= arr_req_o.rd ? 4'h1 : (arr_req_o.wb || rc_ff == 4'h0) ? 4'h0 : rc_ff + 4'h1;
		end
		if (cap_now) cap_ff <= arr_rdata_i;
		if (take) sel_ff <= cpu_req_i.addr[1:0];
		if (take) be_ff <= cpu_req_i.be;
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_cause(logic [2:0] c);
		power_up_clear_o ##1 (system_reset_vector_generator_o == c);
	endsequence
	property p_wb_bound; arr_req_o.rd |-> ##[1:8] arr_req_o.wb; endproperty
	a_wb_bound: assert property (p_wb_bound) else $error("no write-back");
	property p_wb_data;
		arr_req_o.wb |-> arr_req_o.wdata == cap_ff && arr_req_o.wmask == 8'hFF;
	endproperty
	a_wb_data: assert property (p_wb_data) else $error("write-back data");
	property p_miss_wait; arr_req_o.wb |-> rc_ff == {1'b0, w_ff} + 4'h1; endproperty
	a_miss_wait: assert property (p_miss_wait) else $error("wait count");
	property p_miss_ans;
		arr_req_o.wb |-> cpu_ack_o && cpu_rdata_o == cap_ff[sel_ff * 16 +: 16];
	endproperty
	a_miss_ans: assert property (p_miss_ans) else $error("miss answer");
	property p_hit; take && cpu_req_i.rd |=> cpu_ack_o != arr_req_o.rd; endproperty
	a_hit: assert property (p_hit) else $error("read neither hit nor miss");
	property p_wr_mask; arr_req_o.wr |-> arr_req_o.wmask == (8'(be_ff) << (2 * sel_ff)); endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("write mask");
	property p_region;
		arr_req_o.rd || arr_req_o.wr |-> arr_req_o.region == (({arr_req_o.line, 2'h0} <= DESC_HI) ?
			REGION_DESC : (({arr_req_o.line, 2'h0} <= INFO_HI) ? REGION_INFO : REGION_MAIN));
	endproperty
	a_region: assert property (p_region) else $error("array region");
	property p_ready_rst; $fell(srst_i) |=> cpu_ready_o; endproperty
	a_ready_rst: assert property (p_ready_rst) else $error("not ready after reset");
	property p_nmi;
		system_nmi_event_o |-> $past(cap_now && (arr_err_single_i || arr_err_multi_i)) &&
			system_nmi_vector_generator_o == ($past(arr_err_multi_i) ? NMI_SRC_UNC : NMI_SRC_COR);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi source");
	property p_rst_evt;
		system_reset_event_o |-> $past(cap_now && arr_err_multi_i) ##0 s_cause(RST_SRC_UNC);
	endproperty
	a_rst_evt: assert property (p_rst_evt) else $error("reset event");
	property p_timing; clk_wait_need_i > w_ff |=> power_up_clear_o; endproperty
	a_timing: assert property (p_timing) else $error("no clear on timing");
	property p_bad_key; bad_key |=> s_cause(RST_SRC_KEY); endproperty
	a_bad_key: assert property (p_bad_key) else $error("no clear on bad key");
endmodule
bind fac_ctrl fac_ctrl_chk u_chk (.*);

// file: testbench/tb.sv
// self-checking bench of the array access controller
`timescale 1ns/1ps
module tb import fac_pkg::*;;
	logic                 sys_clk_i = 1'b0;
	logic                 srst_i = 1'b1;
	fac_cpu_req_t         cpu_req_i = '0;
	logic [REG_A_W-1:0]   reg_addr_i = '0;
	logic [15:0]          reg_wdata_i = '0;
	logic [1:0]           reg_be_i = '0;
	logic                 reg_wr_i = 1'b0;
	logic                 reg_rd_i = 1'b0;
	logic [WAIT_W-1:0]    clk_wait_need_i = '0;
	logic [1:0]           inj = '0;
	logic [2:0]           wait_cnt = '0;
	fac_arr_req_t         arr_req_o;
	logic [LINE_W-1:0]    arr_rdata_i;
	logic                 arr_err_single_i, arr_err_multi_i, cpu_ready_o, cpu_ack_o;
	logic                 system_nmi_event_o, system_reset_event_o, power_up_clear_o;
	logic [15:0]          cpu_rdata_o, reg_rdata_o, a;
	logic [NMI_SRC_W-1:0] system_nmi_vector_generator_o, nmi_last;
	logic [RST_SRC_W-1:0] system_reset_vector_generator_o;
	logic [15:0]          ref_m [0:255];
	logic [15:0]          lru [6] = '{16'h0480, 16'h0488, 16'h0480, 16'h0490, 16'h0480, 16'h0488};
	int                   lru_lat [6] = '{9, 9, 1, 9, 1, 9};
	int                   failures = 0, tests_run = 0, cyc = 0, pucs = 0, nmis = 0, rsts = 0, n;
	integer               seed = 32'hd5339661;
	logic [1:0]           be;
	always #2.5 sys_clk_i = ~sys_clk_i;
	fac_ctrl dut (.*);
	fac_arr_mdl u_arr (.sys_clk_i, .req_i(arr_req_o), .wait_i(wait_cnt), .inj_i(inj),
		.rdata_o(arr_rdata_i), .err_single_o(arr_err_single_i), .err_multi_o(arr_err_multi_i));
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (power_up_clear_o === 1'b1) pucs <= pucs + 1;
		if (system_reset_event_o === 1'b1) rsts <= rsts + 1;
		if (system_nmi_event_o === 1'b1) nmis <= nmis + 1;
		if (system_nmi_event_o === 1'b1) nmi_last <= system_nmi_vector_generator_o;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic reg_w(input logic [3:0] ad, input logic [1:0] b, input logic [15:0] v);
		@(posedge sys_clk_i);
		{reg_addr_i, reg_be_i, reg_wdata_i, reg_wr_i} <= {ad, b, v, 1'b1};
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic reg_r(input logic [3:0] ad, input logic [15:0] exp);
		@(posedge sys_clk_i);
		{reg_addr_i, reg_rd_i} <= {ad, 1'b1};
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask
	// lat 0 skips the latency compare
	task automatic cpu(input bit w, input logic [15:0] ad, input logic [1:0] b,
		input logic [15:0] v, input int lat);
		@(negedge sys_clk_i);
		while (cpu_ready_o !== 1'b1) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		cpu_req_i <= '{rd: !w, wr: w, addr: ad, wdata: v, be: b};
		@(posedge sys_clk_i);
		cpu_req_i.rd <= 1'b0;
		cpu_req_i.wr <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (cpu_ack_o !== 1'b1 && n < 40);
		if (lat > 0) chk(16'(n), 16'(lat));
		if (!w) chk(cpu_rdata_o, ref_m[ad[7:0]]);
		if (w && ad[15:8] == 8'h04 && b[0]) ref_m[ad[7:0]][7:0] = v[7:0];
		if (w && ad[15:8] == 8'h04 && b[1]) ref_m[ad[7:0]][15:8] = v[15:8];
	endtask
	task automatic ecc(input logic [15:0] gc, input logic [1:0] e, input logic [15:0] ad);
		reg_w(REG_GCTRL0, 2'h3, gc);
		inj <= e;
		cpu(0, ad, 2'h3, 0, 9);
		inj <= 2'h0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 256; i++) ref_m[i] = {8'(i), 8'h5A};
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		reg_r(REG_CTRL0, 16'h9600);
		reg_r(REG_GCTRL0, GC_RESET);
		reg_r(REG_ERRSTAT, 16'h0000);
		reg_r(4'h2, 16'h0000);
		reg_w(REG_GCTRL0, 2'h3, 16'h00E0);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(pucs), 16'd1);
		chk(16'(system_reset_vector_generator_o), 16'(RST_SRC_LOCKED));
		reg_r(REG_GCTRL0, GC_RESET);
		@(posedge sys_clk_i);
		clk_wait_need_i <= 3'h1;
		repeat (3) @(posedge sys_clk_i);
		clk_wait_need_i <= 3'h0;
		repeat (3) @(posedge sys_clk_i);
		chk(16'(pucs), 16'd4);
		chk(16'(system_reset_vector_generator_o), 16'(RST_SRC_TIMING));
		$display("registers and timing done");
		for (int w = 0; w < 8; w++) begin
			reg_w(REG_CTRL0, 2'h3, {KEY_UNLOCK, 1'b0, 3'(w), 4'h0});
			wait_cnt <= 3'(w);
			reg_r(REG_CTRL0, {KEY_READ, 1'b0, 3'(w), 4'h0});
			a = 16'h0400 + 16'(w * 8) + 16'($random(seed) & 3);
			be = 2'($random(seed));
			if (be == 2'h0) be = 2'h3;
			cpu(0, a, 2'h3, 0, 2 + w);
			cpu(0, a ^ 16'h0001, 2'h3, 0, 1);
			cpu(1, a, be, 16'($random(seed)), 2 + w);
			cpu(0, a, 2'h3, 0, 1);
		end
		@(posedge sys_clk_i);
		clk_wait_need_i <= 3'h7;
		repeat (4) @(posedge sys_clk_i);
		clk_wait_need_i <= 3'h0;
		repeat (2) @(posedge sys_clk_i);
		chk(16'(pucs), 16'd4);
		foreach (lru[i]) cpu(0, lru[i], 2'h3, 0, lru_lat[i]);
		cpu(1, 16'h0010, 2'h3, 16'hBEEF, 1);
		cpu(0, 16'h0010, 2'h3, 0, 9);
		cpu(0, 16'h0150, 2'h3, 0, 9);
		$display("wait states and cache done");
		ecc(16'h0026, 2'h1, 16'h04C0);
		chk(16'(nmis), 16'd1);
		chk(16'(nmi_last), 16'(NMI_SRC_COR));
		reg_r(REG_ERRSTAT, 16'h0001);
		reg_w(REG_ERRSTAT, 2'h3, 16'h0001);
		reg_r(REG_ERRSTAT, 16'h0000);
		ecc(GC_RESET, 2'h1, 16'h04C4);
		chk(16'(nmis), 16'd1);
		reg_r(REG_ERRSTAT, 16'h0001);
		ecc(16'h0046, 2'h2, 16'h04C8);
		chk(16'(nmis), 16'd2);
		chk(16'(nmi_last), 16'(NMI_SRC_UNC));
		reg_r(REG_ERRSTAT, 16'h0003);
		ecc(16'h0086, 2'h2, 16'h04CC);
		chk(16'(rsts), 16'd1);
		chk(16'(nmis), 16'd2);
		chk(16'(system_reset_vector_generator_o), 16'(RST_SRC_UNC));
		$display("error events done");
		reg_w(REG_CTRL0, 2'h3, 16'h1200);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(system_reset_vector_generator_o), 16'(RST_SRC_KEY));
		reg_r(REG_CTRL0, 16'h9670);
		reg_w(REG_CTRL0, 2'h3, {KEY_UNLOCK, 8'h70});
		reg_w(REG_CTRL0, 2'h2, 16'h3300);
		reg_w(REG_GCTRL0, 2'h3, 16'h0000);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(system_reset_vector_generator_o), 16'(RST_SRC_LOCKED));
		repeat (16) cpu(0, 16'h0400 | 16'($random(seed) & 8'hFF), 2'h3, 0, 0);
		$display("keys and random reads done");
		conclude();
	end
endmodule
